// >>> hw/oms_pkg.sv
// operating mode select: shared constants and types
package oms_pkg;

   // ----------------------------------------
   // timing and address map values
   // ----------------------------------------
   localparam int unsigned SYNC_STAGES  = 2;     // flops in the pin synchroniser
   localparam logic [1:0]  SETTLE_COUNT = 2'h2;  // cycles after release before capture
   localparam int unsigned ADDR_W       = 16;    // cpu address width
   localparam int unsigned VEC_ADDR_BIT = 14;    // address bit forced low on vector fetch
   localparam logic [15:0] BOOT_BASE    = 16'hbf40; // boot rom window base
   localparam logic [15:0] BOOT_SIZE    = 16'h00c0; // boot rom window size, 192 bytes

   // ----------------------------------------
   // control bits and modes
   // ----------------------------------------
   typedef struct packed {
      logic boot_rom_enable;
      logic special_mode_bit;
      logic expanded_select_bit;
   } oms_ctl_t;

   localparam oms_ctl_t CTL_RESET = '{1'b0, 1'b0, 1'b0}; // value before capture

   typedef enum logic [1:0] {
      MODE_NORMAL_SINGLE,
      MODE_NORMAL_EXPANDED,
      MODE_SPECIAL_BOOT,
      MODE_SPECIAL_TEST
   } oms_mode_t;

   typedef enum logic {
      ST_SETTLE,
      ST_RUN
   } oms_state_t;

endpackage

// >>> hw/oms_sync.sv
// two flop synchroniser for asynchronous level inputs
`timescale 1ns/1ns
module oms_sync #(
   parameter int unsigned WIDTH = 2
) (
   input  wire logic             i_core_clk, // system clock
   input  wire logic             i_nrst,     // async reset, active low
   input  wire logic [WIDTH-1:0] i_async,    // asynchronous levels
   output logic      [WIDTH-1:0] o_sync      // synchronised levels
);

   // an empty bus has nothing to synchronise
   if (WIDTH < 1) begin : g_width_zero
      $error("synchroniser width must be at least one");
   end

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;

   // ----------------------------------------
   // synchroniser chain
   // ----------------------------------------
   // first stage read only by second stage
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         stage1 <= '0;
         stage2 <= '0;
      end else begin
         stage1 <= i_async;
         stage2 <= stage1;
      end
   end

   assign o_sync = stage2;

endmodule

// >>> hw/oms_top.sv
// operating mode select and boot rom enable logic
// Operation
// - expanded bit loaded from mode pin a
// - expanded bit picks single chip or expanded
// - special bit loaded inverted from mode pin b
// - special bit picks normal or special modes
// - special mode permits writing mode control bits
// - special mode forces a14 low on vectors
// - boot enable writable only in special modes
// - boot enable maps boot rom into memory
// - reset sets bits per mode table
`timescale 1ns/1ns
module oms_top #(
   parameter logic [15:0] BOOT_BASE = oms_pkg::BOOT_BASE, // boot rom window base
   parameter logic [15:0] BOOT_SIZE = oms_pkg::BOOT_SIZE  // boot rom window bytes
) (
   input  wire logic                           i_core_clk,      // system clock 50 mhz
   input  wire logic                           i_nrst,          // async reset, active low
   input  wire logic                           i_mode_pin_a,    // mode pin a level
   input  wire logic                           i_mode_pin_b,    // mode pin b level
   input  wire logic                           i_ctl_wr,        // control write strobe
   input  wire oms_pkg::oms_ctl_t              i_ctl_wdata,     // control write data
   input  wire logic [oms_pkg::ADDR_W-1:0]     i_cpu_addr,      // cpu address
   input  wire logic                           i_vector_fetch,  // cpu vector fetch cycle
   output oms_pkg::oms_ctl_t                   o_ctl,           // control bits
   output oms_pkg::oms_mode_t                  o_mode,          // decoded mode
   output logic                                o_mode_valid,    // bits captured
   output logic [oms_pkg::ADDR_W-1:0]          o_bus_addr,      // address to memory
   output logic                                o_boot_rom_sel   // boot rom selected
);

   // ----------------------------------------
   // elaboration checks
   // ----------------------------------------
   // refuse a window the 16-bit decode cannot hold
   if (32'(BOOT_BASE) + 32'(BOOT_SIZE) > 32'h0001_0000) begin : g_window_past_top
      $error("boot rom window runs past the address space");
   end

   // an empty window would never select the rom
   if (BOOT_SIZE == 16'h0000) begin : g_window_empty
      $error("boot rom window is empty");
   end

   // the relocated bit must exist on the address bus
   if (oms_pkg::VEC_ADDR_BIT >= oms_pkg::ADDR_W) begin : g_vec_bit_range
      $error("vector address bit outside the address bus");
   end

   // the pins must be through the synchroniser before they are taken
   if (oms_pkg::SETTLE_COUNT < oms_pkg::SYNC_STAGES) begin : g_settle_short
      $error("settle count shorter than the synchroniser");
   end

   // ----------------------------------------
   // functions
   // ----------------------------------------
   // mode from control bits, special bit picks the pair, expanded bit the member
   function automatic oms_pkg::oms_mode_t mode_of(input oms_pkg::oms_ctl_t c);
      oms_pkg::oms_mode_t m;
      m = oms_pkg::MODE_NORMAL_SINGLE;
      if (c.special_mode_bit) begin
         if (c.expanded_select_bit) begin
            m = oms_pkg::MODE_SPECIAL_TEST;
         end else begin
            m = oms_pkg::MODE_SPECIAL_BOOT;
         end
      end else begin
         if (c.expanded_select_bit) begin
            m = oms_pkg::MODE_NORMAL_EXPANDED;
         end else begin
            m = oms_pkg::MODE_NORMAL_SINGLE;
         end
      end
      return m;
   endfunction

   // address inside boot rom window
   function automatic logic in_boot(input logic [15:0] a);
      logic [16:0] top;
      top = {1'b0, BOOT_BASE} + {1'b0, BOOT_SIZE};
      return (a >= BOOT_BASE) && ({1'b0, a} < top);
   endfunction

   // control bits taken from the synchronised pins as reset is left
   function automatic oms_pkg::oms_ctl_t capture_of(input logic pin_b, input logic pin_a);
      oms_pkg::oms_ctl_t c;
      c.expanded_select_bit = pin_a;
      c.special_mode_bit    = ~pin_b;
      // boot rom only in the special single chip mode
      c.boot_rom_enable     = ~pin_b & ~pin_a;
      return c;
   endfunction

   // ----------------------------------------
   // pin synchroniser
   // ----------------------------------------
   logic [1:0] pins_sync;

   oms_sync #(
      .WIDTH (2)
   ) u_sync (
      .i_core_clk (i_core_clk),
      .i_nrst     (i_nrst),
      .i_async    ({i_mode_pin_b, i_mode_pin_a}),
      .o_sync     (pins_sync)
   );

   // ----------------------------------------
   // capture and control state
   // ----------------------------------------
   oms_pkg::oms_state_t state;
   oms_pkg::oms_state_t next_state;
   logic [1:0]          settle;
   logic [1:0]          next_settle;
   logic                capture;
   oms_pkg::oms_ctl_t   ctl;
   oms_pkg::oms_ctl_t   next_ctl;
   logic                wr_ok;

   // ----------------------------------------
   // capture sequencer
   // ----------------------------------------
   // the synchroniser is cleared by reset, so the pins need two edges
   // to reach it; the bits are taken on the third edge after release
   assign capture = (state == oms_pkg::ST_SETTLE) && (settle == oms_pkg::SETTLE_COUNT);

   // settle count, then run until the next reset
   always_comb begin
      next_state  = state;
      next_settle = settle;
      unique case (state)
         oms_pkg::ST_SETTLE: begin
            if (capture) begin
               next_state = oms_pkg::ST_RUN;
            end else begin
               next_settle = settle + 2'h1;
            end
         end
         oms_pkg::ST_RUN: begin
            next_state = oms_pkg::ST_RUN; // held until reset
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state  <= oms_pkg::ST_SETTLE;
         settle <= 2'h0;
      end else begin
         state  <= next_state;
         settle <= next_settle;
      end
   end

   // ----------------------------------------
   // control bits
   // ----------------------------------------
   // software reaches the bits only after capture and only in a special mode
   assign wr_ok = i_ctl_wr && (state == oms_pkg::ST_RUN) && ctl.special_mode_bit;

   // capture from the pins, then guarded software writes
   always_comb begin
      next_ctl = ctl;
      if (capture) begin
         next_ctl = capture_of(pins_sync[1], pins_sync[0]);
      end else if (wr_ok) begin
         // all three bits change together; clearing special is one way
         next_ctl = i_ctl_wdata;
      end
      // normal modes hold boot enable at zero and ignore writes to it
      if (!next_ctl.special_mode_bit) begin
         next_ctl.boot_rom_enable = 1'b0;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ctl <= oms_pkg::CTL_RESET;
      end else begin
         ctl <= next_ctl;
      end
   end

   // ----------------------------------------
   // registered outputs
   // ----------------------------------------
   oms_pkg::oms_mode_t          next_mode;
   logic [oms_pkg::ADDR_W-1:0]  next_bus_addr;
   logic                        next_boot_sel;
   logic                        next_valid;

   // mode decode follows the bits being registered this edge
   always_comb begin
      next_mode     = mode_of(next_ctl);
      next_valid    = (next_state == oms_pkg::ST_RUN);
      next_bus_addr = i_cpu_addr;
      // vectors move from the top page to the alternate page in special modes;
      // the bit already in force decides, a write lands one edge later
      if (i_vector_fetch && ctl.special_mode_bit) begin
         next_bus_addr[oms_pkg::VEC_ADDR_BIT] = 1'b0;
      end
      // the bootstrap reset vector lies inside the window, so the
      // firmware in the rom runs first
      next_boot_sel = ctl.boot_rom_enable && in_boot(next_bus_addr);
   end

   // every output straight from a flop
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_ctl          <= oms_pkg::CTL_RESET;
         o_mode         <= oms_pkg::MODE_NORMAL_SINGLE;
         o_mode_valid   <= 1'b0;
         o_bus_addr     <= '0;
         o_boot_rom_sel <= 1'b0;
      end else begin
         o_ctl          <= next_ctl;
         o_mode         <= next_mode;
         o_mode_valid   <= next_valid;
         o_bus_addr     <= next_bus_addr;
         o_boot_rom_sel <= next_boot_sel;
      end
   end

endmodule

// >>> verif/oms_top_asserts.sv
// assertions on the mode select ports
`timescale 1ns/1ns
module oms_top_asserts #(
   parameter logic [15:0] BOOT_BASE = oms_pkg::BOOT_BASE, // rom base
   parameter logic [15:0] BOOT_SIZE = oms_pkg::BOOT_SIZE  // rom bytes
) (
   input wire logic               i_core_clk,     // clock
   input wire logic               i_nrst,         // reset
   input wire logic               i_mode_pin_a,   // pin a
   input wire logic               i_mode_pin_b,   // pin b
   input wire logic               i_ctl_wr,       // write
   input wire oms_pkg::oms_ctl_t  i_ctl_wdata,    // data
   input wire logic [15:0]        i_cpu_addr,     // address
   input wire logic               i_vector_fetch, // vector
   input wire oms_pkg::oms_ctl_t  o_ctl,          // bits
   input wire oms_pkg::oms_mode_t o_mode,         // mode
   input wire logic               o_mode_valid,   // valid
   input wire logic [15:0]        o_bus_addr,     // bus address
   input wire logic               o_boot_rom_sel  // rom select
);
   // expected values one cycle ahead
   logic        vec_force;
   logic        boot_now;
   logic [15:0] addr_exp;
   logic [2:0]  wr_exp;
   assign vec_force = i_vector_fetch & o_ctl.special_mode_bit;
   assign boot_now  = o_ctl.boot_rom_enable;
   assign addr_exp  = vec_force ? (i_cpu_addr & 16'hbfff) : i_cpu_addr;
   assign wr_exp    = {i_ctl_wdata.boot_rom_enable & i_ctl_wdata.special_mode_bit,
                       i_ctl_wdata.special_mode_bit, i_ctl_wdata.expanded_select_bit};
   default clocking dc @(posedge i_core_clk);
   endclocking
   default disable iff (!i_nrst);
   a_mode_decode:
      assert property (o_mode == {o_ctl.special_mode_bit, o_ctl.expanded_select_bit})
      else $error("mode differs from bits");
   a_capture_time:
      assert property ($rose(i_nrst) |-> !o_mode_valid [*3] ##1 o_mode_valid)
      else $error("capture late or early");
   a_capture_value:
      assert property ($rose(o_mode_valid) |-> o_ctl ==
         {~i_mode_pin_b & ~i_mode_pin_a, ~i_mode_pin_b, i_mode_pin_a})
      else $error("captured bits wrong");
   a_write_taken:
      assert property (i_ctl_wr && o_mode_valid && o_ctl.special_mode_bit |=>
         o_ctl == $past(wr_exp))
      else $error("write not applied");
   a_bits_hold:
      assert property (o_mode_valid && !(i_ctl_wr && o_ctl.special_mode_bit) |=>
         $stable(o_ctl) && o_mode_valid)
      else $error("bits changed without write");
   a_normal_noboot:
      assert property (!o_ctl.special_mode_bit |-> !o_ctl.boot_rom_enable)
      else $error("boot enable in normal mode");
   a_vector_force:
      assert property ($past(i_nrst) |-> o_bus_addr == $past(addr_exp))
      else $error("bus address wrong");
   a_boot_window:
      assert property ($past(i_nrst) |-> o_boot_rom_sel == ($past(boot_now) &&
         o_bus_addr >= BOOT_BASE &&
         {1'b0, o_bus_addr} < ({1'b0, BOOT_BASE} + {1'b0, BOOT_SIZE})))
      else $error("boot select wrong");
endmodule
bind oms_top oms_top_asserts #(.BOOT_BASE(BOOT_BASE), .BOOT_SIZE(BOOT_SIZE)) oms_top_asserts_i (
   .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_mode_pin_a(i_mode_pin_a),
   .i_mode_pin_b(i_mode_pin_b), .i_ctl_wr(i_ctl_wr), .i_ctl_wdata(i_ctl_wdata),
   .i_cpu_addr(i_cpu_addr), .i_vector_fetch(i_vector_fetch), .o_ctl(o_ctl), .o_mode(o_mode),
   .o_mode_valid(o_mode_valid), .o_bus_addr(o_bus_addr), .o_boot_rom_sel(o_boot_rom_sel));

// >>> verif/testbench.sv
// self-checking bench for operating mode select
`timescale 1ns/1ns
module testbench;
   logic               i_core_clk = 1'b0;
   logic               i_nrst = 1'b0;
   logic               i_mode_pin_a = 1'b0;
   logic               i_mode_pin_b = 1'b1;
   logic               i_ctl_wr = 1'b0;
   oms_pkg::oms_ctl_t  i_ctl_wdata = 3'h0;
   logic [15:0]        i_cpu_addr = 16'h0000;
   logic               i_vector_fetch = 1'b0;
   oms_pkg::oms_ctl_t  o_ctl;
   oms_pkg::oms_mode_t o_mode;
   logic               o_mode_valid;
   logic [15:0]        o_bus_addr;
   logic               o_boot_rom_sel;
   int                 errors = 0;
   int                 compares = 0;
   int                 cycles = 0;
   oms_top oms_top_i (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_mode_pin_a(i_mode_pin_a),
      .i_mode_pin_b(i_mode_pin_b), .i_ctl_wr(i_ctl_wr), .i_ctl_wdata(i_ctl_wdata),
      .i_cpu_addr(i_cpu_addr), .i_vector_fetch(i_vector_fetch), .o_ctl(o_ctl), .o_mode(o_mode),
      .o_mode_valid(o_mode_valid), .o_bus_addr(o_bus_addr), .o_boot_rom_sel(o_boot_rom_sel));
   // clock and cycle ceiling
   always #10 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk) begin
      cycles++;
      if (cycles == 2000) begin
         errors++;
         final_report();
      end
   end
   task automatic final_report();
      if (errors == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask
   function automatic logic [2:0] cap_of(input logic b, input logic a);
      return {~b & ~a, ~b, a};
   endfunction
   // reset with given pins, check capture timing and bits
   task automatic boot_in(input logic b, input logic a);
      i_mode_pin_b = b;
      i_mode_pin_a = a;
      i_nrst = 1'b0;
      tick(4);
      chk(16'(o_ctl), 16'h0000);
      i_nrst = 1'b1;
      tick(2);
      chk(16'(o_mode_valid), 16'h0000);
      tick(1);
      chk(16'(o_ctl), 16'(cap_of(b, a)));
      chk(16'(o_mode), 16'({~b, a}));
      chk(16'(o_mode_valid), 16'h0001);
   endtask
   task automatic ctl_write(input logic [2:0] d, input logic [2:0] exp);
      i_ctl_wdata = d;
      i_ctl_wr = 1'b1;
      tick(1);
      i_ctl_wr = 1'b0;
      chk(16'(o_ctl), 16'(exp));
      chk(16'(o_mode), 16'(exp[1:0]));
      tick(1);
   endtask
   task automatic addr_case(input logic [15:0] a, input logic v, input logic [15:0] ea,
                            input logic es);
      i_cpu_addr = a;
      i_vector_fetch = v;
      tick(1);
      chk(o_bus_addr, ea);
      chk(16'(o_boot_rom_sel), 16'(es));
   endtask
   // every mode, then pin changes and a write after capture
   task automatic t_modes();
      for (int i = 0; i < 4; i++) begin
         boot_in(i[1], i[0]);
         tick(1);
         i_mode_pin_a = ~i[0];
         i_mode_pin_b = ~i[1];
         ctl_write(3'h7, i[1] ? cap_of(i[1], i[0]) : 3'h7);
         tick(2);
         chk(16'(o_ctl), 16'(i[1] ? cap_of(i[1], i[0]) : 3'h7));
      end
   endtask
   // bootstrap: vector relocation, rom window, leaving special mode
   task automatic t_boot();
      boot_in(1'b0, 1'b0);
      addr_case(16'hfffe, 1'b1, 16'hbffe, 1'b1);
      addr_case(16'hfffe, 1'b0, 16'hfffe, 1'b0);
      addr_case(16'hbf40, 1'b0, 16'hbf40, 1'b1);
      addr_case(16'hbf3f, 1'b0, 16'hbf3f, 1'b0);
      addr_case(16'hc000, 1'b0, 16'hc000, 1'b0);
      ctl_write(3'h3, 3'h3);
      addr_case(16'hbfff, 1'b0, 16'hbfff, 1'b0);
      addr_case(16'hfffe, 1'b1, 16'hbffe, 1'b0);
      ctl_write(3'h5, 3'h1);
      ctl_write(3'h6, 3'h1);
      addr_case(16'hfffe, 1'b1, 16'hfffe, 1'b0);
   endtask
   initial begin
      t_modes();
      t_boot();
      final_report();
   end
endmodule
